// >>> design/aiin_handler.sv
// Identify words 85-128, Idle, Idle Immediate and NOP command handler
//
// Overview of operation
// - Word 87 reads 4000h, validity marker set.
// - Word 85 bits 3,12,13,14 always one.
// - Word 85 bits 0,2,4,7-10 always zero.
// - Word 85 bits 5,6,1 follow live settings.
// - Word 86 only bit 3, set when APM enabled.
// - Ultra DMA and multiword DMA never both selected.
// - Word 88 bits 14:8 one-hot selected mode.
// - Word 88 support bits are cumulative.
// - Word 88 zero without Ultra DMA support.
// - Word 89 holds erase time in two-minute units.
// - Word 92 holds last master password revision.
// - Word 128 bit 8 only at maximum level.
// - Expired count sticky; unlock and erase aborted.
// - Word 128 bits 5,3,2,1,0 report security state.
// - Idle: busy, idle mode, unbusy, then interrupt.
// - Idle count loads 5 ms power-down timer.
// - Idle Immediate same sequence, task file ignored.
// - NOP always ends with aborted command.
`timescale 1ns/1ps
module aiin_handler #(
	parameter int          APD_UNIT_CYC = aiin_pkg::AIIN_APD_UNIT_CYC,
	parameter bit          UDMA_SUP     = 1'b1,
	parameter logic [2:0]  UDMA_MAX     = 3'h6,
	parameter bit          SEC_ENH      = 1'b1
) (
	input  wire logic        clk_i,               // 25 MHz clock
	input  wire logic        nrst_i,              // Async reset, low
	input  wire logic [7:0]  avs_address_i,       // Byte address
	input  wire logic        avs_read_i,          // Read request
	input  wire logic        avs_write_i,         // Write request
	input  wire logic [31:0] avs_writedata_i,     // Write data
	input  wire logic [3:0]  avs_byteenable_i,    // Byte lanes
	output logic      [31:0] avs_readdata_o,      // Read data
	output logic             avs_waitrequest_o,   // Stall
	output logic             busy_o,              // Command busy
	output logic             intrq_o,             // Host interrupt
	output logic             standby_o            // Powered down
);
	import aiin_pkg::*;

	////////////////////////////////////////////////////////////////////
	// State
	logic          wait_ff;
	logic [31:0]   rdata_ff;
	aiin_feat_type feat_ff;
	aiin_xfer_type xfer_ff;
	logic [15:0]   eraset_ff;
	logic [15:0]   mrev_ff;
	logic [7:0]    idx_ff;
	logic [7:0]    fails_ff;
	logic          expired_ff;
	aiin_cmd_type  cmd_st_ff;
	logic [7:0]    code_ff;
	logic [7:0]    count_ff;
	logic [1:0]    exec_ff;
	logic          busy_ff;
	logic          intrq_ff;
	logic          abrt_ff;
	logic          idle_ff;
	logic          stby_ff;
	logic          apden_ff;
	logic [7:0]    apd_units_ff;
	logic [31:0]   apd_tick_ff;

	logic          acc;
	logic          wr;
	logic          wr_lo;
	logic          cmd_go;
	logic [15:0]   w85;
	logic [15:0]   w86;
	logic [15:0]   w88;
	logic [15:0]   w128;
	logic [15:0]   id_word;
	logic [31:0]   rd_mux;
	logic [6:0]    udma_sup_bits;

	////////////////////////////////////////////////////////////////////
	// Avalon slave: one wait cycle, then a single acknowledge cycle
	assign acc   = (avs_read_i | avs_write_i) & wait_ff;
	assign wr    = avs_write_i & ~wait_ff;
	assign wr_lo = wr & avs_byteenable_i[0];

	// Waitrequest drops for exactly one cycle per access
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~acc;
		end
	end

	// Read data captured with the acknowledge, stable at its edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (acc && avs_read_i) begin
			rdata_ff <= rd_mux;
		end
	end

	assign avs_waitrequest_o = wait_ff;
	assign avs_readdata_o    = rdata_ff;
	assign busy_o            = busy_ff;
	assign intrq_o           = intrq_ff;
	assign standby_o         = stby_ff;

	////////////////////////////////////////////////////////////////////
	// Firmware settings
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			feat_ff   <= '0;
			eraset_ff <= 16'h0000;
			mrev_ff   <= 16'hfffe;
			idx_ff    <= 8'h00;
		end else if (wr) begin
			case (avs_address_i)
				AIIN_OFS_FEAT:   if (avs_byteenable_i[0]) begin
					feat_ff <= aiin_feat_type'(avs_writedata_i[6:0]);
				end
				AIIN_OFS_ERASET: if (&avs_byteenable_i[1:0]) begin
					eraset_ff <= avs_writedata_i[15:0];
				end
				AIIN_OFS_MREV:   if (&avs_byteenable_i[1:0]) begin
					mrev_ff <= avs_writedata_i[15:0];
				end
				AIIN_OFS_IDX:    if (avs_byteenable_i[0]) begin
					idx_ff <= avs_writedata_i[7:0];
				end
				default: ;
			endcase
		end
	end

	// Transfer mode: one field, so a new selection replaces the old one
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			xfer_ff <= '0;
		end else if (wr_lo && avs_address_i == AIIN_OFS_XFER) begin
			xfer_ff <= aiin_xfer_type'(avs_writedata_i[4:0]);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Security attempt counter, cleared only by reset
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fails_ff   <= 8'h00;
			expired_ff <= 1'b0;
		end else if (wr_lo && avs_address_i == AIIN_OFS_SECFAIL &&
		             avs_writedata_i[0] && !expired_ff) begin
			fails_ff   <= fails_ff + 8'h01;
			expired_ff <= (fails_ff + 8'h01) >= AIIN_SEC_TRIES;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Identify words
	assign udma_sup_bits = 7'((8'h01 << (UDMA_MAX + 3'h1)) - 8'h01);

	always_comb begin
		w85                = AIIN_W85_FIXED;
		w85[AIIN_W85_WC]   = feat_ff.wcache;
		w85[AIIN_W85_LA]   = feat_ff.lookahead;
		w85[AIIN_W85_SE]   = feat_ff.sec_en;
		w86                = 16'h0000;
		w86[AIIN_W86_APM]  = feat_ff.apm;
		w88                = {9'h000, udma_sup_bits};
		if (xfer_ff.valid && xfer_ff.udma && xfer_ff.mode <= UDMA_MAX) begin
			w88[AIIN_W88_SEL + 32'(xfer_ff.mode)] = 1'b1;
		end
		if (!UDMA_SUP) begin
			w88 = 16'h0000;
		end
		w128 = {7'h00, feat_ff.sec_en & feat_ff.sec_max,
		        2'b00, SEC_ENH, expired_ff, feat_ff.sec_frz,
		        feat_ff.sec_lock, feat_ff.sec_en, 1'b1};
	end

	always_comb begin
		case (idx_ff)
			AIIN_W85:  id_word = w85;
			AIIN_W86:  id_word = w86;
			AIIN_W87:  id_word = AIIN_W87_VAL;
			AIIN_W88:  id_word = w88;
			AIIN_W89:  id_word = eraset_ff;
			AIIN_W92:  id_word = mrev_ff;
			AIIN_W128: id_word = w128;
			default:   id_word = 16'h0000;
		endcase
	end

	// Register read map; unmapped offsets read zero
	always_comb begin
		case (avs_address_i)
			AIIN_OFS_CMD:     rd_mux = {16'h0000, count_ff, code_ff};
			AIIN_OFS_STATUS:  rd_mux = {26'h0, apden_ff, stby_ff, idle_ff,
			                            abrt_ff, intrq_ff, busy_ff};
			AIIN_OFS_FEAT:    rd_mux = {25'h0, feat_ff};
			AIIN_OFS_XFER:    rd_mux = {27'h0, xfer_ff};
			AIIN_OFS_SECFAIL: rd_mux = {23'h0, expired_ff, fails_ff};
			AIIN_OFS_ERASET:  rd_mux = {16'h0000, eraset_ff};
			AIIN_OFS_MREV:    rd_mux = {16'h0000, mrev_ff};
			AIIN_OFS_IDX:     rd_mux = {24'h0, idx_ff};
			AIIN_OFS_IDDATA:  rd_mux = {16'h0000, id_word};
			AIIN_OFS_APD:     rd_mux = {24'h0, apd_units_ff};
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Command engine; a command written while busy is dropped
	assign cmd_go = wr_lo && avs_address_i == AIIN_OFS_CMD &&
	                cmd_st_ff == CMD_IDLE;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_st_ff <= CMD_IDLE;
			code_ff   <= 8'h00;
			count_ff  <= 8'h00;
			exec_ff   <= 2'h0;
			busy_ff   <= 1'b0;
		end else begin
			case (cmd_st_ff)
				CMD_IDLE: if (cmd_go) begin
					code_ff   <= avs_writedata_i[7:0];
					count_ff  <= avs_byteenable_i[1] ?
					             avs_writedata_i[15:8] : 8'h00;
					busy_ff   <= 1'b1;
					exec_ff   <= AIIN_EXEC_CYC;
					cmd_st_ff <= CMD_EXEC;
				end
				CMD_EXEC: begin
					exec_ff <= exec_ff - 2'h1;
					if (exec_ff == 2'h1) begin
						cmd_st_ff <= CMD_DONE;
					end
				end
				CMD_DONE: begin
					busy_ff   <= 1'b0;
					cmd_st_ff <= CMD_IRQ;
				end
				CMD_IRQ:  cmd_st_ff <= CMD_IDLE;
				default:  cmd_st_ff <= CMD_IDLE;
			endcase
		end
	end

	// Interrupt: set after busy drops; set wins over a status clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			intrq_ff <= 1'b0;
		end else if (cmd_st_ff == CMD_IRQ) begin
			intrq_ff <= 1'b1;
		end else if (cmd_go || (wr_lo && avs_address_i == AIIN_OFS_STATUS &&
		             avs_writedata_i[AIIN_ST_INTRQ])) begin
			intrq_ff <= 1'b0;
		end
	end

	// Error outcome decided when execution ends
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			abrt_ff <= 1'b0;
		end else if (cmd_go) begin
			abrt_ff <= 1'b0;
		end else if (cmd_st_ff == CMD_DONE) begin
			case (code_ff)
				AIIN_CMD_NOP:    abrt_ff <= 1'b1;
				AIIN_CMD_UNLOCK,
				AIIN_CMD_ERASE:  abrt_ff <= expired_ff;
				AIIN_CMD_IDLE_A, AIIN_CMD_IDLE_B,
				AIIN_CMD_IDLEI_A, AIIN_CMD_IDLEI_B,
				AIIN_CMD_IDENT:  abrt_ff <= 1'b0;
				default:         abrt_ff <= 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Idle mode and automatic power-down timer
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			idle_ff      <= 1'b0;
			stby_ff      <= 1'b0;
			apden_ff     <= 1'b0;
			apd_units_ff <= 8'h00;
			apd_tick_ff  <= 32'h0;
		end else if (cmd_st_ff == CMD_EXEC && exec_ff == AIIN_EXEC_CYC) begin
			case (code_ff)
				AIIN_CMD_IDLE_A, AIIN_CMD_IDLE_B: begin
					idle_ff      <= 1'b1;
					stby_ff      <= 1'b0;
					apden_ff     <= count_ff != 8'h00;
					apd_units_ff <= count_ff;
					apd_tick_ff  <= 32'(APD_UNIT_CYC - 1);
				end
				AIIN_CMD_IDLEI_A, AIIN_CMD_IDLEI_B: begin
					idle_ff     <= 1'b1;
					stby_ff     <= 1'b0;
					apd_tick_ff <= 32'(APD_UNIT_CYC - 1);
				end
				default: ;
			endcase
		end else if (apden_ff && idle_ff && !busy_ff) begin
			if (apd_tick_ff != 32'h0) begin
				apd_tick_ff <= apd_tick_ff - 32'h1;
			end else if (apd_units_ff == 8'h01) begin
				idle_ff      <= 1'b0;
				stby_ff      <= 1'b1;
				apden_ff     <= 1'b0;
				apd_units_ff <= 8'h00;
			end else begin
				apd_units_ff <= apd_units_ff - 8'h01;
				apd_tick_ff  <= 32'(APD_UNIT_CYC - 1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_w87_valid;
		@(posedge clk_i) disable iff (!nrst_i)
		(idx_ff == AIIN_W87 && acc && avs_read_i &&
		 avs_address_i == AIIN_OFS_IDDATA) |=> rdata_ff == 32'h0000_4000;
	endproperty
	a_w87_valid: assert property (p_w87_valid)
		else $error("word 87 not 4000h");

	property p_w85_bits;
		@(posedge clk_i) disable iff (!nrst_i)
		(w85 & 16'h779d) == 16'h7008 && w85[5] == feat_ff.wcache &&
		w85[6] == feat_ff.lookahead && w85[1] == feat_ff.sec_en;
	endproperty
	a_w85_bits: assert property (p_w85_bits)
		else $error("word 85 fixed bits wrong");

	property p_w86_apm;
		@(posedge clk_i) disable iff (!nrst_i)
		$rose(feat_ff.apm) |-> w86 == 16'h0008;
	endproperty
	a_w86_apm: assert property (p_w86_apm)
		else $error("word 86 apm bit wrong");

	property p_w88_sel;
		@(posedge clk_i) disable iff (!nrst_i)
		$onehot0(w88[14:8]) && !w88[15] && !w88[7];
	endproperty
	a_w88_sel: assert property (p_w88_sel)
		else $error("word 88 selection not one-hot");

	property p_w88_follow;
		@(posedge clk_i) disable iff (!nrst_i)
		(wr_lo && avs_address_i == AIIN_OFS_XFER && !avs_writedata_i[3])
		|=> w88[14:8] == 7'h00;
	endproperty
	a_w88_follow: assert property (p_w88_follow)
		else $error("multiword select left ultra mode set");

	property p_w128_max;
		@(posedge clk_i) disable iff (!nrst_i)
		w128[8] |-> (feat_ff.sec_en && feat_ff.sec_max);
	endproperty
	a_w128_max: assert property (p_w128_max)
		else $error("word 128 level bit without max level");

	property p_expired_abort;
		@(posedge clk_i) disable iff (!nrst_i)
		(cmd_st_ff == CMD_DONE && expired_ff &&
		 (code_ff == AIIN_CMD_UNLOCK || code_ff == AIIN_CMD_ERASE))
		|=> abrt_ff ##0 $stable(expired_ff);
	endproperty
	a_expired_abort: assert property (p_expired_abort)
		else $error("unlock or erase not aborted after expiry");

	property p_nop_abort;
		@(posedge clk_i) disable iff (!nrst_i)
		(cmd_go && avs_writedata_i[7:0] == AIIN_CMD_NOP)
		|-> ##4 (!busy_ff && abrt_ff) ##1 intrq_ff;
	endproperty
	a_nop_abort: assert property (p_nop_abort)
		else $error("nop did not abort");

	property p_idle_seq;
		@(posedge clk_i) disable iff (!nrst_i)
		(cmd_go && (avs_writedata_i[7:0] == AIIN_CMD_IDLE_A ||
		            avs_writedata_i[7:0] == AIIN_CMD_IDLEI_B))
		|=> busy_ff ##1 idle_ff ##2 (!busy_ff && !intrq_ff) ##1 intrq_ff;
	endproperty
	a_idle_seq: assert property (p_idle_seq)
		else $error("idle sequence out of order");

	property p_apd_load;
		@(posedge clk_i) disable iff (!nrst_i)
		(cmd_go && avs_writedata_i[7:0] == AIIN_CMD_IDLE_B &&
		 avs_byteenable_i[1])
		|-> ##2 apden_ff == ($past(avs_writedata_i[15:8], 2) != 8'h00);
	endproperty
	a_apd_load: assert property (p_apd_load)
		else $error("power-down timer not loaded");
endmodule

// >>> design/aiin_pkg.sv
// Constants, encodings and carrier types for the identify/idle/nop handler
package aiin_pkg;
	// Register byte offsets
	localparam logic [7:0] AIIN_OFS_CMD      = 8'h00;
	localparam logic [7:0] AIIN_OFS_STATUS   = 8'h04;
	localparam logic [7:0] AIIN_OFS_FEAT     = 8'h08;
	localparam logic [7:0] AIIN_OFS_XFER     = 8'h0c;
	localparam logic [7:0] AIIN_OFS_SECFAIL  = 8'h10;
	localparam logic [7:0] AIIN_OFS_ERASET   = 8'h14;
	localparam logic [7:0] AIIN_OFS_MREV     = 8'h18;
	localparam logic [7:0] AIIN_OFS_IDX      = 8'h1c;
	localparam logic [7:0] AIIN_OFS_IDDATA   = 8'h20;
	localparam logic [7:0] AIIN_OFS_APD      = 8'h24;
	// Command codes
	localparam logic [7:0] AIIN_CMD_IDLE_A   = 8'h97;
	localparam logic [7:0] AIIN_CMD_IDLE_B   = 8'he3;
	localparam logic [7:0] AIIN_CMD_IDLEI_A  = 8'h95;
	localparam logic [7:0] AIIN_CMD_IDLEI_B  = 8'he1;
	localparam logic [7:0] AIIN_CMD_NOP      = 8'h00;
	localparam logic [7:0] AIIN_CMD_IDENT    = 8'hec;
	localparam logic [7:0] AIIN_CMD_UNLOCK   = 8'hf2;
	localparam logic [7:0] AIIN_CMD_ERASE    = 8'hf4;
	// Identify word numbers
	localparam logic [7:0] AIIN_W85  = 8'd85;
	localparam logic [7:0] AIIN_W86  = 8'd86;
	localparam logic [7:0] AIIN_W87  = 8'd87;
	localparam logic [7:0] AIIN_W88  = 8'd88;
	localparam logic [7:0] AIIN_W89  = 8'd89;
	localparam logic [7:0] AIIN_W92  = 8'd92;
	localparam logic [7:0] AIIN_W128 = 8'd128;
	// Fixed identify contents
	localparam logic [15:0] AIIN_W85_FIXED = 16'h7008;
	localparam logic [15:0] AIIN_W87_VAL   = 16'h4000;
	localparam int AIIN_W85_WC = 5;
	localparam int AIIN_W85_LA = 6;
	localparam int AIIN_W85_SE = 1;
	localparam int AIIN_W86_APM = 3;
	localparam int AIIN_W88_SEL = 8;
	localparam int AIIN_W128_MAX = 8;
	// Status bit positions
	localparam int AIIN_ST_BUSY  = 0;
	localparam int AIIN_ST_INTRQ = 1;
	localparam int AIIN_ST_ABRT  = 2;
	localparam int AIIN_ST_IDLE  = 3;
	localparam int AIIN_ST_STBY  = 4;
	localparam int AIIN_ST_APDEN = 5;
	// Timing
	localparam int AIIN_CLK_HZ      = 25_000_000;
	localparam int AIIN_APD_UNIT_US = 5000;
	localparam int AIIN_APD_UNIT_CYC =
		AIIN_APD_UNIT_US * (AIIN_CLK_HZ / 1_000_000);
	localparam logic [1:0] AIIN_EXEC_CYC = 2'h2;
	localparam logic [7:0] AIIN_SEC_TRIES = 8'h05;

	// Feature and security settings written by firmware
	typedef struct packed {
		logic wcache;
		logic lookahead;
		logic apm;
		logic sec_en;
		logic sec_lock;
		logic sec_frz;
		logic sec_max;
	} aiin_feat_type;

	// Selected transfer mode: one register so only one can stand
	typedef struct packed {
		logic       valid;
		logic       udma;
		logic [2:0] mode;
	} aiin_xfer_type;

	typedef enum {
		CMD_IDLE,
		CMD_EXEC,
		CMD_DONE,
		CMD_IRQ
	} aiin_cmd_type;
endpackage

// >>> verif/aiin_host_model.sv
// Host controller model: Avalon-MM master issuing task-file accesses
`timescale 1ns/1ps
module aiin_host_model (
	input  wire logic        clk_i,          // Bus clock
	input  wire logic [31:0] readdata_i,     // Slave read data
	input  wire logic        waitrequest_i,  // Slave stall
	output logic      [7:0]  address_o,      // Byte address
	output logic             read_o,         // Read request
	output logic             write_o,        // Write request
	output logic      [31:0] writedata_o,    // Write data
	output logic      [3:0]  byteenable_o    // Byte lanes
);
	////////////////////////////////////////////////////////////////////////
	// Idle bus at time zero
	initial begin
		address_o    = 8'h00;
		read_o       = 1'b0;
		write_o      = 1'b0;
		writedata_o  = 32'h0000_0000;
		byteenable_o = 4'hf;
	end

	////////////////////////////////////////////////////////////////////////
	// Write: request held until waitrequest is seen low at an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		address_o   <= a;
		writedata_o <= d;
		write_o     <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		write_o     <= 1'b0;
		writedata_o <= ~d; // Stale data never looks valid
	endtask

	// Read: data taken at the same edge that ends the wait
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		address_o <= a;
		read_o    <= 1'b1;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		d = readdata_i;
		read_o    <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Enabled-feature words carry information only if not 0000h or FFFFh
	function automatic logic feat_known(input logic [15:0] w);
		return (w !== 16'h0000) && (w !== 16'hffff);
	endfunction
endmodule

// >>> verif/test_aiin_handler.sv
// Self-checking bench for the identify/idle/nop handler
`timescale 1ns/1ps
module test_aiin_handler;
	import aiin_pkg::*;
	localparam int UNIT = 20;  // Short power-down unit for simulation
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  adr;
	logic        rd_s;
	logic        wr_s;
	logic [31:0] wdat;
	logic [3:0]  be;
	logic [31:0] rdat;
	logic        wait_s;
	logic        busy_o;
	logic        intrq_o;
	logic        standby_o;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc = 0;

	////////////////////////////////////////////////////////////////////////
	// Device and host
	aiin_handler #(.APD_UNIT_CYC(UNIT)) u_dut (
		.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_s), .busy_o(busy_o), .intrq_o(intrq_o),
		.standby_o(standby_o));
	aiin_host_model u_host (
		.clk_i(clk_i), .readdata_i(rdat), .waitrequest_i(wait_s),
		.address_o(adr), .read_o(rd_s), .write_o(wr_s),
		.writedata_o(wdat), .byteenable_o(be));

	// Clock and hang guard; ceiling well above the planned run
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic conclude();
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	task automatic do_reset();
		nrst_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask

	task automatic id_chk(input logic [7:0] w, input logic [15:0] exp);
		logic [31:0] d;
		u_host.wr(AIIN_OFS_IDX, {24'h0, w});
		u_host.rd(AIIN_OFS_IDDATA, d);
		chk(d, {16'h0, exp}, "identify word");
	endtask

	// Issue one command, follow busy then interrupt, then check status
	task automatic run_cmd(input logic [7:0] code, cnt, input logic abrt);
		logic [31:0] st;
		int n;
		u_host.wr(AIIN_OFS_CMD, {16'h0, cnt, code});
		@(posedge clk_i);
		chk(busy_o, 1'b1, "busy after command");
		n = 0;
		while (intrq_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk(intrq_o, 1'b1, "interrupt raised");
		chk(busy_o, 1'b0, "busy gone at interrupt");
		u_host.rd(AIIN_OFS_STATUS, st);
		chk(st[AIIN_ST_ABRT], abrt, "abort flag");
		u_host.wr(AIIN_OFS_STATUS, 32'h2);
		@(posedge clk_i);
		chk(intrq_o, 1'b0, "interrupt cleared");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_fixed();
		logic [31:0] d;
		u_host.rd(8'h28, d);
		chk(d, 32'h0, "unmapped read");
		u_host.wr(AIIN_OFS_FEAT, 32'h0);
		id_chk(AIIN_W87, 16'h4000);
		id_chk(AIIN_W85, 16'h7008);
		id_chk(AIIN_W86, 16'h0000);
		chk(u_host.feat_known(16'h4000), 1'b1, "host view");
	endtask

	task automatic t_feat();
		logic [6:0]  f[4] = '{7'h40, 7'h20, 7'h08, 7'h10};
		logic [15:0] e85[4] = '{16'h7028, 16'h7048, 16'h700a, 16'h7008};
		logic [15:0] e86[4] = '{16'h0, 16'h0, 16'h0, 16'h0008};
		for (int i = 0; i < 4; i++) begin
			u_host.wr(AIIN_OFS_FEAT, {25'h0, f[i]});
			id_chk(AIIN_W85, e85[i]);
			id_chk(AIIN_W86, e86[i]);
		end
	endtask

	task automatic t_udma();
		id_chk(AIIN_W88, 16'h007f);
		for (int m = 0; m < 7; m++) begin
			u_host.wr(AIIN_OFS_XFER, {27'h0, 2'b11, m[2:0]});
			id_chk(AIIN_W88, 16'h007f | (16'h1 << (8 + m)));
		end
		u_host.wr(AIIN_OFS_XFER, 32'h12);
		id_chk(AIIN_W88, 16'h007f);
	endtask

	task automatic t_words();
		u_host.wr(AIIN_OFS_ERASET, 32'h1234);
		id_chk(AIIN_W89, 16'h1234);
		id_chk(AIIN_W92, 16'hfffe);
		u_host.wr(AIIN_OFS_MREV, 32'h0abc);
		id_chk(AIIN_W92, 16'h0abc);
	endtask

	task automatic t_sec();
		logic [6:0]  f[4] = '{7'h09, 7'h01, 7'h0e, 7'h08};
		logic [15:0] e[4] = '{16'h0123, 16'h0021, 16'h002f, 16'h0023};
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			u_host.wr(AIIN_OFS_FEAT, {25'h0, f[i]});
			id_chk(AIIN_W128, e[i]);
		end
		repeat (4) u_host.wr(AIIN_OFS_SECFAIL, 32'h1);
		id_chk(AIIN_W128, 16'h0023);
		run_cmd(AIIN_CMD_UNLOCK, 8'h00, 1'b0);
		u_host.wr(AIIN_OFS_SECFAIL, 32'h1);
		id_chk(AIIN_W128, 16'h0033);
		u_host.rd(AIIN_OFS_SECFAIL, d);
		chk(d[8], 1'b1, "expired flag");
		run_cmd(AIIN_CMD_UNLOCK, 8'h00, 1'b1);
		run_cmd(AIIN_CMD_ERASE, 8'h00, 1'b1);
		do_reset();
		id_chk(AIIN_W128, 16'h0021);
		run_cmd(AIIN_CMD_ERASE, 8'h00, 1'b0);
	endtask

	// Idle family, power-down timer, NOP
	task automatic t_idle();
		logic [31:0] st;
		int c0;
		c0 = cyc;
		run_cmd(AIIN_CMD_IDLE_A, 8'h03, 1'b0);
		while (standby_o !== 1'b1 && cyc - c0 < 5 * UNIT) @(posedge clk_i);
		chk(standby_o, 1'b1, "standby reached");
		chk(cyc - c0 >= 3 * UNIT, 1'b1, "standby not early");
		u_host.rd(AIIN_OFS_STATUS, st);
		chk(st[5:3], 3'b010, "standby status");
		run_cmd(AIIN_CMD_IDLE_B, 8'h04, 1'b0);
		u_host.rd(AIIN_OFS_STATUS, st);
		chk({st[5], st[3]}, 2'b11, "power-down armed");
		run_cmd(AIIN_CMD_IDLE_B, 8'h00, 1'b0);
		u_host.rd(AIIN_OFS_STATUS, st);
		chk(st[5], 1'b0, "power-down off");
		run_cmd(AIIN_CMD_IDLEI_B, 8'h05, 1'b0);
		run_cmd(AIIN_CMD_IDLEI_A, 8'h09, 1'b0);
		u_host.rd(AIIN_OFS_STATUS, st);
		chk({st[5], st[3]}, 2'b01, "count ignored");
		run_cmd(AIIN_CMD_NOP, 8'h00, 1'b1);
		run_cmd(AIIN_CMD_NOP, 8'h07, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		do_reset();
		t_fixed();
		t_feat();
		t_udma();
		t_words();
		t_idle();
		t_sec();
		conclude();
	end
endmodule
